// *** design/tws_regs.svh ***
// Register offsets, field positions, reset values and timing counts
// Assumes a 32-bit APB slave with byte addresses on an 8-bit paddr
`ifndef TWS_REGS_SVH
`define TWS_REGS_SVH
`define TWS_CTRL_OFS 8'h00
`define TWS_STAT_OFS 8'h04
`define TWS_DATA_OFS 8'h08
`define TWS_OWN_OFS 8'h0c
`define TWS_DIV_OFS 8'h10
`define TWS_C_EN 3
`define TWS_C_MSEL 2
`define TWS_C_TX 1
`define TWS_C_ACKDIS 0
`define TWS_S_FLAG 4
`define TWS_S_BUSY 3
`define TWS_S_AAS 2
`define TWS_S_SRW 1
`define TWS_S_RECEIVED_ACK_STATUS 0
`define TWS_OWN_RST 7'h00
`define TWS_CLK_HZ 10000000
`define TWS_STD_KBPS 100
`define TWS_PH_PER_BIT 4
`define TWS_DIV_RST (`TWS_CLK_HZ / (`TWS_STD_KBPS * 1000 * `TWS_PH_PER_BIT) - 1)
`define TWS_DIV_MIN 4
`endif

// *** design/tws_pkg.sv ***
// Types of the two-wire controller: states and state records
// Assumes the offsets and counts come from tws_regs.svh
package tws_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_START = 4'h1,
    ST_MWAIT = 4'h3,
    ST_MBIT = 4'h2,
    ST_STOP = 4'h6,
    ST_SADDR = 4'h7,
    ST_SACK = 4'h5,
    ST_SHOLD = 4'h4,
    ST_SRX = 4'hc,
    ST_STX = 4'hd,
    ST_SSKIP = 4'hf
  } tws_state_e;
  typedef struct packed {
    tws_state_e st;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic en;
    logic msel;
    logic tx;
    logic ackdis;
    logic flag;
    logic busy;
    logic aas;
    logic slave_read_write_status;
    logic received_ack_status;
    logic go;
    logic [6:0] own;
    logic [7:0] div;
    logic [7:0] sh;
    logic [7:0] rxd;
    logic scl_oe;
    logic sda_oe;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } tws_core_s;
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } tws_tick_s;
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_p;
    logic sda_p;
  } tws_det_s;
endpackage

// *** design/tws_line_if.sv ***
// Sampled bus lines and bus events passed from the detector to the core
// Assumes both ends run on the core clock
interface tws_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  modport det (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
  modport core (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

// *** design/tws_tick.sv ***
// Phase enable divider: one-cycle pulse every div+1 clocks
// Assumes div is held at or above the minimum by the register logic
module tws_tick
  import tws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic en_i,
  input wire logic [7:0] div_i,
  output logic tick_o
);
  tws_tick_s r;
  tws_tick_s n;

  always_comb begin
    n = r;
    n.tick = 1'b0;
    if (!en_i) begin
      n.cnt = 8'h00;
    end else if (r.cnt >= div_i) begin
      n.cnt = 8'h00;
      n.tick = 1'b1;
    end else begin
      n.cnt = r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign tick_o = r.tick;
endmodule // tws_tick

// *** design/tws_cond_det.sv ***
// Bus line sampler with clock edge, start and stop detection
// Assumes scl_i and sda_i are already synchronous to the clock
module tws_cond_det
  import tws_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  tws_line_if.det ln
);
  tws_det_s r;
  tws_det_s n;

  always_comb begin
    n = r;
    n.scl = scl_i;
    n.sda = sda_i;
    n.scl_p = r.scl;
    n.sda_p = r.sda;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= 4'hf;
    end else begin
      r <= n;
    end
  end

  assign ln.scl = r.scl;
  assign ln.sda = r.sda;
  assign ln.scl_rise = r.scl && !r.scl_p;
  assign ln.scl_fall = !r.scl && r.scl_p;
  assign ln.start_det = r.scl && r.scl_p && r.sda_p && !r.sda;
  assign ln.stop_det = r.scl && r.scl_p && !r.sda_p && r.sda;
endmodule // tws_cond_det

// *** design/tws_ctrl.sv ***
// Two-wire bus controller, master and addressed slave, with APB registers
// Assumes APB on core_clk_i, bus pins synchronous, open-drain wired outside
`include "tws_regs.svh"

// Function
// - Start is SDA falling while SCL high, generated as master, detected as slave.
// - Stop is SDA rising while SCL high, ending the transaction.
// - Data bits change SDA only while SCL is low.
// - Eight data bits then a ninth acknowledge bit driven low by receiver.
// - First byte after start is the address; only a matching device acknowledges.
// - Address LSB one means master reads, zero means master writes.
// - A slave may hold SCL low; master waits for release before continuing.
// - Supports 100 kbps and bit rates up to clock divided by twenty.
// - Setting master select with transmit direction set drives a start.
// - Master transmit: data write shifts byte out, flag set after acknowledge slot.
// - Master receive: dummy data read clocks the first byte in.
// - After a received byte, acknowledge unless disabled, then set the flag.
// - Master receive: every data read fetches the next byte.
// - Received acknowledge status records the slave answer to the last byte.
// - Clearing master select generates a stop.
// - Slave: address match sets the flag; controller acknowledges the address itself.
// - Slave read/write status reports direction; software sets transmit bit to match.
// - Receiving slave holds SCL low until software reads the data register.
// - Transmitting slave holds SCL low until software writes the data register.
// - Flag is raised after every byte sent or received.
// - Lost arbitration clears master select by hardware.
module tws_ctrl
  import tws_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] rst_sync_r;
  logic rst_n;
  tws_core_s r;
  tws_core_s n;
  logic tick;
  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic wr_data;
  logic rd_data;
  logic set_flag;
  logic clr_flag;
  logic slave_st;

  tws_line_if ln ();

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  tws_tick u_tick (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .en_i(r.en),
    .div_i(r.div),
    .tick_o(tick)
  );

  tws_cond_det u_det (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ln(ln)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    n = r;
    setup = psel_i && !penable_i;
    acc = psel_i && penable_i && r.pready;
    wr = acc && pwrite_i && !r.pslverr;
    rd = acc && !pwrite_i && !r.pslverr;
    wr_data = wr && (paddr_i == `TWS_DATA_OFS);
    rd_data = rd && (paddr_i == `TWS_DATA_OFS);
    clr_flag = wr && (paddr_i == `TWS_STAT_OFS) && pwdata_i[`TWS_S_FLAG];
    set_flag = 1'b0;
    slave_st = r.st inside {ST_IDLE, ST_SSKIP, ST_SADDR, ST_SACK, ST_SHOLD, ST_SRX, ST_STX};
    // Bus slave: read data and error captured in the setup cycle
    n.pready = setup;
    n.pslverr = 1'b0;
    if (setup) begin
      n.prdata = 32'h0;
      if (paddr_i == `TWS_CTRL_OFS) begin
        n.prdata[3:0] = {r.en, r.msel, r.tx, r.ackdis};
      end else if (paddr_i == `TWS_STAT_OFS) begin
        n.prdata[4:0] = {r.flag, r.busy, r.aas, r.slave_read_write_status, r.received_ack_status};
      end else if (paddr_i == `TWS_DATA_OFS) begin
        n.prdata[7:0] = r.rxd;
      end else if (paddr_i == `TWS_OWN_OFS) begin
        n.prdata[6:0] = r.own;
      end else if (paddr_i == `TWS_DIV_OFS) begin
        n.prdata[7:0] = r.div;
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (wr && (paddr_i == `TWS_CTRL_OFS)) begin
      n.en = pwdata_i[`TWS_C_EN];
      n.msel = pwdata_i[`TWS_C_MSEL];
      n.tx = pwdata_i[`TWS_C_TX];
      n.ackdis = pwdata_i[`TWS_C_ACKDIS];
    end
    if (wr && (paddr_i == `TWS_OWN_OFS)) begin
      n.own = pwdata_i[6:0];
    end
    if (wr && (paddr_i == `TWS_DIV_OFS)) begin
      n.div = (pwdata_i[7:0] < 8'(`TWS_DIV_MIN)) ? 8'(`TWS_DIV_MIN) : pwdata_i[7:0];
    end
    if (ln.start_det) begin
      n.busy = 1'b1;
    end else if (ln.stop_det) begin
      n.busy = 1'b0;
    end
    //////////////////////////////////////////////////////////////////////////
    if (!r.en) begin
      n.st = ST_IDLE;
      n.scl_oe = 1'b0;
      n.sda_oe = 1'b0;
      n.aas = 1'b0;
      n.go = 1'b0;
    end else begin
      case (r.st)
        ST_IDLE, ST_SSKIP: begin
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          if (r.msel && r.tx && !r.busy) begin
            n.st = ST_START;
            n.ph = 2'd0;
            n.go = 1'b0;
          end
        end
        ST_START: begin
          // Early data write is kept and sent once the start is done
          if (wr_data && r.tx) begin
            n.sh = pwdata_i[7:0];
            n.go = 1'b1;
          end
          if (tick) begin
            n.ph = r.ph + 2'd1;
            if (r.ph == 2'd0 && !ln.scl) begin
              n.ph = r.ph;
            end else if (r.ph == 2'd1) begin
              n.sda_oe = 1'b1;
            end else if (r.ph == 2'd3) begin
              n.scl_oe = 1'b1;
              n.st = ST_MWAIT;
            end
          end
        end
        ST_MWAIT: begin
          n.scl_oe = 1'b1;
          if (tick) begin
            n.sda_oe = 1'b0;
          end
          if (!r.msel) begin
            n.st = ST_STOP;
            n.ph = 2'd0;
          end else if ((wr_data || r.go) && r.tx) begin
            n.sh = wr_data ? pwdata_i[7:0] : r.sh;
            n.go = 1'b0;
            n.st = ST_MBIT;
            n.ph = 2'd0;
            n.bitc = 4'd0;
          end else if (rd_data && !r.tx) begin
            n.st = ST_MBIT;
            n.ph = 2'd0;
            n.bitc = 4'd0;
          end
        end
        ST_MBIT: if (tick) begin
          n.ph = r.ph + 2'd1;
          case (r.ph)
            2'd0: n.scl_oe = 1'b1;
            2'd1: begin
              if (r.bitc == 4'd8) begin
                n.sda_oe = r.tx ? 1'b0 : !r.ackdis;
              end else begin
                n.sda_oe = r.tx && !r.sh[7];
              end
            end
            2'd2: n.scl_oe = 1'b0;
            default: begin
              if (!ln.scl) begin
                n.ph = r.ph;
              end else if (r.bitc == 4'd8) begin
                n.st = ST_MWAIT;
                n.scl_oe = 1'b1;
                set_flag = 1'b1;
                if (r.tx) begin
                  n.received_ack_status = ln.sda;
                end else begin
                  n.rxd = r.sh;
                end
              end else if (r.tx && r.sh[7] && !ln.sda) begin
                n.msel = 1'b0;
                n.st = ST_IDLE;
                n.scl_oe = 1'b0;
                n.sda_oe = 1'b0;
                set_flag = 1'b1;
              end else begin
                n.sh = {r.sh[6:0], ln.sda};
                n.bitc = r.bitc + 4'd1;
              end
            end
          endcase
        end
        ST_STOP: if (tick) begin
          n.ph = r.ph + 2'd1;
          case (r.ph)
            2'd0: n.sda_oe = 1'b1;
            2'd1: n.scl_oe = 1'b0;
            2'd2: if (!ln.scl) n.ph = r.ph;
            default: begin
              n.sda_oe = 1'b0;
              n.st = ST_IDLE;
            end
          endcase
        end
        ST_SADDR, ST_SRX: begin
          if (ln.scl_rise && r.bitc < 4'd8) begin
            n.sh = {r.sh[6:0], ln.sda};
            n.bitc = r.bitc + 4'd1;
          end else if (ln.scl_fall && r.bitc == 4'd8) begin
            n.st = ST_SACK;
            if (r.st == ST_SRX) begin
              n.rxd = r.sh;
              n.sda_oe = !r.ackdis;
            end else if (r.sh[7:1] == r.own) begin
              n.rxd = r.sh;
              n.sda_oe = 1'b1;
              n.aas = 1'b1;
              n.slave_read_write_status = r.sh[0];
            end else begin
              n.st = ST_SSKIP;
            end
          end
        end
        ST_SACK: begin
          if (ln.scl_rise && !r.sda_oe) begin
            n.received_ack_status = ln.sda;
          end else if (ln.scl_fall) begin
            n.sda_oe = 1'b0;
            set_flag = 1'b1;
            if (!r.sda_oe && r.received_ack_status) begin
              n.st = ST_SSKIP;
            end else begin
              n.scl_oe = 1'b1;
              n.st = ST_SHOLD;
              n.go = 1'b0;
            end
          end
        end
        ST_SHOLD: begin
          n.scl_oe = 1'b1;
          if (r.go) begin
            if (tick) begin
              n.scl_oe = 1'b0;
              n.go = 1'b0;
              n.bitc = 4'd0;
              n.st = r.tx ? ST_STX : ST_SRX;
            end
          end else if (wr_data && r.tx) begin
            n.sh = pwdata_i[7:0];
            n.sda_oe = !pwdata_i[7];
            n.go = 1'b1;
          end else if (rd_data && !r.tx) begin
            n.go = 1'b1;
          end
        end
        ST_STX: if (ln.scl_fall) begin
          if (r.bitc == 4'd7) begin
            n.sda_oe = 1'b0;
            n.st = ST_SACK;
          end else begin
            n.sh = {r.sh[6:0], 1'b0};
            n.sda_oe = !r.sh[6];
            n.bitc = r.bitc + 4'd1;
          end
        end
        default: n.st = ST_IDLE;
      endcase
      if (!r.msel && slave_st) begin
        if (ln.stop_det) begin
          n.st = ST_IDLE;
          n.aas = 1'b0;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.go = 1'b0;
        end else if (ln.start_det) begin
          n.st = ST_SADDR;
          n.bitc = 4'd0;
          n.aas = 1'b0;
          n.scl_oe = 1'b0;
          n.sda_oe = 1'b0;
          n.go = 1'b0;
        end
      end
    end
    n.flag = (r.flag && !clr_flag) || set_flag;
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.div <= 8'(`TWS_DIV_RST);
      r.own <= `TWS_OWN_RST;
    end else begin
      r <= n;
    end
  end

  assign prdata_o = r.prdata;
  assign pready_o = r.pready;
  assign pslverr_o = r.pslverr;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = r.scl_oe;
  assign sda_oe_o = r.sda_oe;

  ////////////////////////////////////////////////////////////////////////////
  property p_start_gen;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.st == ST_START && $rose(r.sda_oe) |-> ln.scl && !r.scl_oe;
  endproperty
  a_start_gen: assert property (p_start_gen) else $error("Start without SCL high");

  property p_stop_gen;
    @(posedge core_clk_i) disable iff (!rst_n)
      $past(r.st) == ST_STOP && $fell(r.sda_oe) |-> !r.scl_oe && $past(ln.scl);
  endproperty
  a_stop_gen: assert property (p_stop_gen) else $error("Stop without SCL high");

  property p_sda_low_phase;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.st inside {ST_MBIT, ST_STX} && $changed(r.sda_oe) |-> $past(r.scl_oe) || !$past(ln.scl);
  endproperty
  a_sda_low_phase: assert property (p_sda_low_phase) else $error("SDA moved with SCL high");

  property p_stretch_wait;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && r.st == ST_MBIT && r.ph == 2'd3 && !ln.scl |=> r.ph == 2'd3 && !r.scl_oe;
  endproperty
  a_stretch_wait: assert property (p_stretch_wait) else $error("Master ran past held SCL");

  property p_div_min;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.div >= 8'(`TWS_DIV_MIN);
  endproperty
  a_div_min: assert property (p_div_min) else $error("Divider below minimum");

  property p_start_req;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && r.st == ST_IDLE && r.msel && r.tx && !r.busy && !wr |=> r.st == ST_START;
  endproperty
  a_start_req: assert property (p_start_req) else $error("No start after master select");

  property p_tx_launch;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && r.st == ST_MWAIT && r.msel && r.tx && (wr_data || r.go)
      |=> r.st == ST_MBIT && r.bitc == 4'd0;
  endproperty
  a_tx_launch: assert property (p_tx_launch) else $error("Data write did not start byte");

  property p_mrx_ack;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.st == ST_MBIT && r.bitc == 4'd8 && r.ph == 2'd2 && !r.tx |-> r.sda_oe == !r.ackdis;
  endproperty
  a_mrx_ack: assert property (p_mrx_ack) else $error("Wrong master acknowledge");

  property p_received_ack_status_rec;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && tick && r.st == ST_MBIT && r.bitc == 4'd8 && r.ph == 2'd3 && ln.scl && r.tx
      |=> r.received_ack_status == $past(ln.sda) && r.flag;
  endproperty
  a_received_ack_status_rec: assert property (p_received_ack_status_rec) else $error("Acknowledge not recorded");

  property p_stop_req;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && r.st == ST_MWAIT && !r.msel && !wr |=> r.st == ST_STOP;
  endproperty
  a_stop_req: assert property (p_stop_req) else $error("No stop after master clear");

  property p_addr_dir;
    @(posedge core_clk_i) disable iff (!rst_n)
      $rose(r.aas) |-> r.slave_read_write_status == r.rxd[0] && r.rxd[7:1] == r.own && r.sda_oe;
  endproperty
  a_addr_dir: assert property (p_addr_dir) else $error("Address match state wrong");

  property p_slave_hold;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.st == ST_SHOLD && !r.go |-> r.scl_oe;
  endproperty
  a_slave_hold: assert property (p_slave_hold) else $error("Slave released SCL early");

  property p_flag_src;
    @(posedge core_clk_i) disable iff (!rst_n)
      $rose(r.flag) |-> $past(r.st) inside {ST_MBIT, ST_SACK};
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("Flag set outside byte end");

  property p_arb_lost;
    @(posedge core_clk_i) disable iff (!rst_n)
      $past(r.st) == ST_MBIT && r.st == ST_IDLE && r.en |-> !r.msel && r.flag;
  endproperty
  a_arb_lost: assert property (p_arb_lost) else $error("Arbitration loss kept master");

  property p_stop_idle;
    @(posedge core_clk_i) disable iff (!rst_n)
      r.en && !r.msel && slave_st && ln.stop_det && !wr |=> r.st == ST_IDLE && !r.scl_oe;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("Slave ignored stop");
endmodule // tws_ctrl

// *** dv/tws_bus_slave.sv ***
// Behavioural target device on the two-wire bus
// Assumes the bench resolves both open-drain lines with pull-ups
module tws_bus_slave #(
  parameter logic [6:0] ADDR = 7'h29
) (
  input wire logic clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic [7:0] stretch_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic [7:0] rx_byte_o,
  output logic mack_o,
  output logic [7:0] stops_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic scl_q = 1'b1;
  logic sda_q = 1'b1;
  logic [3:0] bitc = 4'h0;
  logic [7:0] sh = 8'h00;
  logic [7:0] txs = 8'h00;
  logic [7:0] nrd = 8'h00;
  logic [7:0] hold = 8'h00;
  logic adr = 1'b0;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic [7:0] nxt;
  assign nxt = tx_byte_i + nrd;
  assign scl_oe_o = (hold != 8'h00);
  initial begin
    sda_oe_o = 1'b0;
    rx_byte_o = 8'h00;
    mack_o = 1'b0;
    stops_o = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    scl_q <= scl_i;
    sda_q <= sda_i;
    if (hold != 8'h00) hold <= hold - 8'h01;
    if (scl_i && scl_q && sda_q && !sda_i) begin
      bitc <= 4'h0;
      adr <= 1'b1;
      sel <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (scl_i && scl_q && !sda_q && sda_i) begin
      adr <= 1'b0;
      sel <= 1'b0;
      sda_oe_o <= 1'b0;
      stops_o <= stops_o + 8'h01;
    end else if (scl_i && !scl_q) begin
      if (bitc < 4'h8) sh <= {sh[6:0], sda_i};
      if (bitc == 4'h8 && sel && rd && !adr) begin
        mack_o <= sda_i;
        sel <= !sda_i;
      end
      bitc <= bitc + 4'h1;
    end else if (!scl_i && scl_q) begin
      if (bitc == 4'h8 && adr) begin
        sel <= (sh[7:1] == ADDR);
        rd <= sh[0];
        sda_oe_o <= (sh[7:1] == ADDR);
        nrd <= 8'h00;
      end else if (bitc == 4'h8) begin
        if (sel && !rd) rx_byte_o <= sh;
        sda_oe_o <= sel && !rd;
      end else if (bitc == 4'h9) begin
        bitc <= 4'h0;
        adr <= 1'b0;
        hold <= stretch_i;
        txs <= nxt;
        nrd <= nrd + 8'h01;
        sda_oe_o <= sel && rd && !nxt[7];
      end else if (sel && rd && !adr) begin
        sda_oe_o <= !txs[3'(4'h7 - bitc)];
      end
    end
  end
endmodule // tws_bus_slave

// *** dv/tb_top.sv ***
// Self-checking bench: APB master, bus target model, master and slave scenarios
// Assumes the controller and the target share pulled-up SCL and SDA wires
`include "tws_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [6:0] ADDR = 7'h29;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0] tx_byte = 8'h00;
  logic [7:0] stretch = 8'h00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic d_scl_oe;
  logic d_sda_oe;
  logic m_scl_oe;
  logic m_sda_oe;
  logic scl_w;
  logic sda_w;
  logic scl_q = 1'b1;
  logic [7:0] rx_byte;
  logic mack;
  logic [7:0] stops;
  logic [31:0] rd;
  logic err;
  logic [7:0] d;
  logic [6:0] own;
  logic s;
  logic t_scl_oe = 1'b0;
  logic t_sda_oe = 1'b0;
  int seed;
  int fails = 0;
  int num_checks = 0;
  int cyc = 0;
  int lastr = 0;
  int per = 0;
  int i;
  assign scl_w = !(d_scl_oe || m_scl_oe || t_scl_oe);
  assign sda_w = !(d_sda_oe || m_sda_oe || t_sda_oe);
  tws_ctrl u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_w),
    .scl_o(), .scl_oe_o(d_scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe_o(d_sda_oe));
  tws_bus_slave #(.ADDR(ADDR)) u_peer (.clk_i(core_clk_i), .scl_i(scl_w), .sda_i(sda_w),
    .tx_byte_i(tx_byte), .stretch_i(stretch), .scl_oe_o(m_scl_oe), .sda_oe_o(m_sda_oe),
    .rx_byte_o(rx_byte), .mack_o(mack), .stops_o(stops));
  initial begin
    forever #50 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    scl_q <= scl_w;
    if (scl_w && !scl_q) begin
      per <= cyc - lastr;
      lastr <= cyc;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int bit_clocks(input int div);
    return 4 * (div + 1);
  endfunction
  function automatic logic [31:0] exp_rd(input logic [7:0] b, input logic [7:0] k);
    return {24'h0, 8'(b + k)};
  endfunction
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tmo();
    fails++;
    print_verdict();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_flag();
    int k;
    k = 0;
    do begin
      apb(1'b0, `TWS_STAT_OFS, 32'h0);
      k++;
    end while (rd[`TWS_S_FLAG] !== 1'b1 && k < 300);
    if (rd[`TWS_S_FLAG] !== 1'b1) tmo();
  endtask
  task automatic wait_stop(input logic [7:0] n);
    int k;
    for (k = 0; k < 2000 && stops !== n; k++) @(posedge core_clk_i);
    check(32'(stops), 32'(n));
  endtask
  task automatic start_addr(input logic [7:0] ab);
    apb(1'b1, `TWS_CTRL_OFS, 32'he);
    apb(1'b1, `TWS_DATA_OFS, {24'h0, ab});
    wait_flag();
  endtask
  task automatic wait_scl();
    int k;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (scl_w !== 1'b1 && k < 500);
    if (scl_w !== 1'b1) tmo();
    repeat (10) @(posedge core_clk_i);
  endtask
  task automatic bus_clk(input logic b, output logic sv);
    @(posedge core_clk_i);
    t_sda_oe <= !b;
    repeat (10) @(posedge core_clk_i);
    t_scl_oe <= 1'b0;
    wait_scl();
    sv = sda_w;
    t_scl_oe <= 1'b1;
  endtask
  task automatic bus_byte(input logic [7:0] b, output logic sv);
    for (int j = 7; j >= 0; j--) bus_clk(b[j], sv);
    bus_clk(1'b1, sv);
  endtask
  task automatic bus_cond(input logic stop);
    @(posedge core_clk_i);
    t_sda_oe <= 1'b1;
    repeat (10) @(posedge core_clk_i);
    t_scl_oe <= !stop;
    if (stop) begin
      wait_scl();
      t_sda_oe <= 1'b0;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 19;
    repeat (2) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    for (i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check(rd, (i == 4) ? 32'd24 : 32'h0);
      check(32'(err), 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, `TWS_DIV_OFS, 32'h2);
    apb(1'b0, `TWS_DIV_OFS, 32'h0);
    check(rd, 32'(`TWS_DIV_MIN));
    apb(1'b1, `TWS_DIV_OFS, 32'h4);
    for (i = 0; i < 3; i++) begin
      d = 8'($random(seed));
      stretch <= 8'h20 | (8'($random(seed)) & 8'h1f);
      start_addr({ADDR, 1'b0});
      check(32'(rd[`TWS_S_RECEIVED_ACK_STATUS]), 32'h0);
      apb(1'b1, `TWS_STAT_OFS, 32'h10);
      apb(1'b1, `TWS_DATA_OFS, {24'h0, d});
      wait_flag();
      check(32'(rx_byte), 32'(d));
      check(32'(rd[`TWS_S_RECEIVED_ACK_STATUS]), 32'h0);
      check(32'(per), 32'(bit_clocks(4)));
      apb(1'b1, `TWS_STAT_OFS, 32'h10);
      apb(1'b1, `TWS_CTRL_OFS, 32'ha);
      wait_stop(8'(i + 1));
    end
    d = 8'($random(seed));
    tx_byte <= d;
    start_addr({ADDR, 1'b1});
    check(32'(rd[`TWS_S_RECEIVED_ACK_STATUS]), 32'h0);
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b1, `TWS_CTRL_OFS, 32'hc);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    wait_flag();
    check(32'(mack), 32'h0);
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b1, `TWS_CTRL_OFS, 32'hd);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd, exp_rd(d, 8'h00));
    wait_flag();
    check(32'(mack), 32'h1);
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b1, `TWS_CTRL_OFS, 32'h8);
    wait_stop(8'h04);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd, exp_rd(d, 8'h01));
    start_addr({ADDR ^ (7'($random(seed)) | 7'h01), 1'b0});
    check(32'(rd[`TWS_S_RECEIVED_ACK_STATUS]), 32'h1);
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b1, `TWS_CTRL_OFS, 32'ha);
    wait_stop(8'h05);
    own = 7'($random(seed)) | 7'h40;
    d = 8'($random(seed));
    apb(1'b1, `TWS_OWN_OFS, {25'h0, own});
    apb(1'b1, `TWS_CTRL_OFS, 32'h8);
    bus_cond(1'b0);
    bus_byte({own, 1'b0}, s);
    check(32'(s), 32'h0);
    wait_flag();
    check(32'(rd[3:1]), 32'h6);
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd, {24'h0, own, 1'b0});
    bus_byte(d, s);
    check(32'(s), 32'h0);
    wait_flag();
    apb(1'b1, `TWS_STAT_OFS, 32'h10);
    apb(1'b0, `TWS_DATA_OFS, 32'h0);
    check(rd, {24'h0, d});
    bus_cond(1'b1);
    wait_stop(8'h06);
    apb(1'b0, `TWS_STAT_OFS, 32'h0);
    check(32'(rd[3:2]), 32'h0);
    print_verdict();
  end
  initial begin
    repeat (100000) @(posedge core_clk_i);
    tmo();
  end
endmodule // tb_top
